// *** src/tsmc_ctrl.sv ***
// timer slave-mode controller: trigger select, slave modes, registers, interrupt
// Functional notes
// - sync enable set keeps this timer synchronised to its master; clear means none.
// - trigger select codes 000..011 pick internal trigger lines zero to three.
// - trigger select 100 picks the channel-1 raw input edge detector.
// - trigger select 101 picks filtered input one, 110 filtered input two.
// - trigger select 111 picks the polarity-conditioned external trigger.
// - switch select 0 uses external trigger, 1 uses output-off signal for raw outputs.
// - slave mode 000 disables slave control; counter runs on internal clock.
// - slave modes 001, 010, 011 select encoder modes A, B, C.
// - slave mode 100: each trigger rising edge reinitialises the counter.
// - slave mode 101: counter advances only while trigger is high.
// - slave mode 110: each trigger rising edge generates a trigger event.
// - slave mode 111: each trigger rising edge clocks the counter once.
// - polarity 0 means high or rising, 1 means low or falling.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module tsmc_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic [3:0] internal_trigger_line,
   input wire logic chan1_edge_detect,
   input wire logic filtered_input_one,
   input wire logic filtered_input_two,
   input wire logic external_trigger_in,
   input wire logic output_off_signal,
   input wire logic int_clk_tick,
   output logic selected_trigger_in,
   output logic raw_channel_switch,
   output logic cnt_reinit,
   output logic cnt_step,
   output logic enc_enable,
   output logic [1:0] enc_mode,
   output logic trig_event,
   output logic trig_flag,
   output logic dma_req,
   output logic master_sync,
   output logic irq
);
   localparam int ST_WIDTH_L = tsmc_pkg::ST_WIDTH;
   logic [15:0] ctrl_q;
   logic [ST_WIDTH_L-1:0] status_q;
   logic [ST_WIDTH_L-1:0] status_d;
   logic [ST_WIDTH_L-1:0] irq_en_q;

   tsmc_trig_if trig ();
   tsmc_edge u_edge (
      .clk(clk),
      .rst(rst),
      .trig(trig)
   );

   // field decode
   wire logic sync_enable = ctrl_q[tsmc_pkg::SYNC_BIT];
   wire logic [2:0] trigger_input_select = ctrl_q[tsmc_pkg::TIS_LSB +: 3];
   wire logic cos_sel = ctrl_q[tsmc_pkg::COSW_BIT];
   wire logic [2:0] slave_mode_select = ctrl_q[tsmc_pkg::SMS_LSB +: 3];
   wire logic ext_polarity = ctrl_q[tsmc_pkg::POL_BIT];

   function automatic tsmc_pkg::tsmc_mode_type mode_of(input logic [2:0] code);
      mode_of = tsmc_pkg::tsmc_mode_type'(8'h01 << code);
   endfunction
   wire tsmc_pkg::tsmc_mode_type mode = mode_of(slave_mode_select);

   // external trigger conditioned by polarity
   wire logic ext_cond = external_trigger_in ^ ext_polarity;

   // trigger source mux
   logic trig_sel;
   always_comb begin
      trig_sel = internal_trigger_line[trigger_input_select[1:0]];
      if (trigger_input_select == tsmc_pkg::TIS_CH1_EDGE) begin
         trig_sel = chan1_edge_detect;
      end else if (trigger_input_select == tsmc_pkg::TIS_FILT1) begin
         trig_sel = filtered_input_one;
      end else if (trigger_input_select == tsmc_pkg::TIS_FILT2) begin
         trig_sel = filtered_input_two;
      end else if (trigger_input_select == tsmc_pkg::TIS_EXT) begin
         trig_sel = ext_cond;
      end
   end
   assign trig.level = trig_sel;
   wire logic rise = trig.rise;

   // raw channel output switch source
   wire logic switch_d = cos_sel ? output_off_signal : ext_cond;

   // slave behaviour decode
   logic reinit_d;
   logic step_d;
   logic event_d;
   logic enc_d;
   logic [1:0] encm_d;
   always_comb begin
      reinit_d = 1'b0;
      step_d = 1'b0;
      event_d = 1'b0;
      enc_d = 1'b0;
      encm_d = 2'h0;
      unique case (mode)
         tsmc_pkg::SM_OFF: begin
            step_d = int_clk_tick;
         end
         tsmc_pkg::SM_ENC_A: begin
            enc_d = 1'b1;
            encm_d = 2'h1;
         end
         tsmc_pkg::SM_ENC_B: begin
            enc_d = 1'b1;
            encm_d = 2'h2;
         end
         tsmc_pkg::SM_ENC_C: begin
            enc_d = 1'b1;
            encm_d = 2'h3;
         end
         tsmc_pkg::SM_RESET: begin
            reinit_d = rise;
            step_d = int_clk_tick & ~rise;
         end
         tsmc_pkg::SM_GATED: begin
            step_d = int_clk_tick & trig.level_q;
         end
         tsmc_pkg::SM_TRIGGER: begin
            event_d = rise;
            step_d = int_clk_tick;
         end
         tsmc_pkg::SM_EXTCLK: begin
            step_d = rise;
         end
      endcase
   end

   // sticky status: set wins over clear
   wire logic clr_wr = wr && (addr == tsmc_pkg::ADDR_IRQ_CLR);
   wire logic [ST_WIDTH_L-1:0] set_v = {step_d & (mode == tsmc_pkg::SM_EXTCLK), reinit_d, event_d};
   assign status_d = (status_q & ~(clr_wr ? wdata[ST_WIDTH_L-1:0] : 3'h0)) | set_v;

   // register read decode
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      if (addr == tsmc_pkg::ADDR_CTRL) begin
         rd_mux = ctrl_q & 16'h80ff;
      end else if (addr == tsmc_pkg::ADDR_STATUS) begin
         rd_mux = {13'h0000, status_q};
      end else if (addr == tsmc_pkg::ADDR_IRQ_EN) begin
         rd_mux = {13'h0000, irq_en_q};
      end else if (addr == tsmc_pkg::ADDR_STATE) begin
         rd_mux = {14'h0000, trig.level_q, sync_enable};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= tsmc_pkg::CTRL_RESET;
         irq_en_q <= tsmc_pkg::STATUS_RESET;
         status_q <= tsmc_pkg::STATUS_RESET;
      end else begin
         if (wr && addr == tsmc_pkg::ADDR_CTRL) begin
            ctrl_q <= wdata & 16'h80ff;
         end
         if (wr && addr == tsmc_pkg::ADDR_IRQ_EN) begin
            irq_en_q <= wdata[ST_WIDTH_L-1:0];
         end
         status_q <= status_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 16'h0000;
         selected_trigger_in <= 1'b0;
         raw_channel_switch <= 1'b0;
         cnt_reinit <= 1'b0;
         cnt_step <= 1'b0;
         enc_enable <= 1'b0;
         enc_mode <= 2'h0;
         trig_event <= 1'b0;
         dma_req <= 1'b0;
         master_sync <= 1'b0;
      end else begin
         rdata <= rd ? rd_mux : 16'h0000;
         selected_trigger_in <= trig_sel;
         raw_channel_switch <= switch_d;
         cnt_reinit <= reinit_d;
         cnt_step <= step_d;
         enc_enable <= enc_d;
         enc_mode <= encm_d;
         trig_event <= event_d;
         dma_req <= event_d;
         // slave mirrors the master's trigger edges only when enabled
         master_sync <= sync_enable & rise;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trig_flag <= 1'b0;
         irq <= 1'b0;
      end else begin
         trig_flag <= status_d[tsmc_pkg::ST_TRIG];
         irq <= |(status_d & irq_en_q);
      end
   end

   a_reset_edge : assert property (@(posedge clk) disable iff (rst)
      (mode == tsmc_pkg::SM_RESET && rise) |=> cnt_reinit) else $error("no reinit on edge");
   a_gate_low : assert property (@(posedge clk) disable iff (rst)
      (mode == tsmc_pkg::SM_GATED && !trig.level_q) |=> !cnt_step) else $error("step while gated");
   a_trig_event : assert property (@(posedge clk) disable iff (rst)
      (mode == tsmc_pkg::SM_TRIGGER && rise) |=> (trig_event && trig_flag)) else $error("trigger lost");
   a_extclk_step : assert property (@(posedge clk) disable iff (rst)
      (mode == tsmc_pkg::SM_EXTCLK) |=> (cnt_step == $past(rise))) else $error("ext clock step wrong");
   a_off_quiet : assert property (@(posedge clk) disable iff (rst)
      (mode == tsmc_pkg::SM_OFF) |=> (!cnt_reinit && !trig_event && !enc_enable)) else $error("slave active");
   a_enc_mode : assert property (@(posedge clk) disable iff (rst)
      (slave_mode_select inside {3'h1, 3'h2, 3'h3}) |=> (enc_enable && enc_mode == $past(slave_mode_select[1:0])))
      else $error("encoder mode wrong");
   a_ext_select : assert property (@(posedge clk) disable iff (rst)
      (trigger_input_select == tsmc_pkg::TIS_EXT) |=> (selected_trigger_in == $past(ext_cond)))
      else $error("external trigger not routed");
   a_sync_off : assert property (@(posedge clk) disable iff (rst)
      !sync_enable |=> !master_sync) else $error("sync while disabled");
   a_flag_sticky : assert property (@(posedge clk) disable iff (rst)
      (trig_flag && !clr_wr) |=> trig_flag) else $error("flag dropped");
   a_switch_src : assert property (@(posedge clk) disable iff (rst)
      cos_sel |=> (raw_channel_switch == $past(output_off_signal))) else $error("switch source wrong");
   c_reset_mode : cover property (@(posedge clk) disable iff (rst) mode == tsmc_pkg::SM_RESET && rise);
   c_trig_irq : cover property (@(posedge clk) disable iff (rst) trig_event ##1 irq);
   c_extclk : cover property (@(posedge clk) disable iff (rst) mode == tsmc_pkg::SM_EXTCLK && rise);
   c_gated_step : cover property (@(posedge clk) disable iff (rst)
      mode == tsmc_pkg::SM_GATED && cnt_step);
   c_enc_on : cover property (@(posedge clk) disable iff (rst)
      enc_enable && enc_mode == 2'h3);

   // source routing, each code checked against its own input
   a_sel_internal : assert property (@(posedge clk) disable iff (rst)
      (trigger_input_select[2] == 1'b0) |=> (selected_trigger_in == $past(internal_trigger_line[trigger_input_select[1:0]])))
      else $error("internal line not routed");
   a_sel_edge : assert property (@(posedge clk) disable iff (rst)
      (trigger_input_select == tsmc_pkg::TIS_CH1_EDGE) |=> (selected_trigger_in == $past(chan1_edge_detect)))
      else $error("channel edge not routed");
   a_sel_filt_one : assert property (@(posedge clk) disable iff (rst)
      (trigger_input_select == tsmc_pkg::TIS_FILT1) |=> (selected_trigger_in == $past(filtered_input_one)))
      else $error("filtered one not routed");
   a_sel_filt_two : assert property (@(posedge clk) disable iff (rst)
      (trigger_input_select == tsmc_pkg::TIS_FILT2) |=> (selected_trigger_in == $past(filtered_input_two)))
      else $error("filtered two not routed");
   // inverted polarity must flip the pin, not pass it through
   a_ext_polarity : assert property (@(posedge clk) disable iff (rst)
      (trigger_input_select == tsmc_pkg::TIS_EXT && ext_polarity) |=> (selected_trigger_in != $past(external_trigger_in)))
      else $error("polarity not applied");
   a_switch_ext : assert property (@(posedge clk) disable iff (rst)
      !cos_sel |=> (raw_channel_switch == $past(ext_cond))
      ) else $error("switch not from external trigger");

   // slave behaviours
   a_off_tick : assert property (@(posedge clk) disable iff (rst)
      (mode == tsmc_pkg::SM_OFF) |=> (cnt_step == $past(int_clk_tick))
      ) else $error("internal clock not followed");
   a_enc_off : assert property (@(posedge clk) disable iff (rst)
      !(slave_mode_select inside {3'h1, 3'h2, 3'h3}) |=> !enc_enable
      ) else $error("encoder on outside its modes");
   a_reset_no_edge : assert property (@(posedge clk) disable iff (rst)
      (mode == tsmc_pkg::SM_RESET && !rise) |=> !cnt_reinit
      ) else $error("reinit without edge");
   // a reinit cycle must not also count
   a_reset_no_step : assert property (@(posedge clk) disable iff (rst)
      (mode == tsmc_pkg::SM_RESET && rise) |=> !cnt_step
      ) else $error("step beside reinit");
   a_gate_high : assert property (@(posedge clk) disable iff (rst)
      (mode == tsmc_pkg::SM_GATED && trig.level_q && int_clk_tick) |=> cnt_step
      ) else $error("gated tick lost");
   a_extclk_quiet : assert property (@(posedge clk) disable iff (rst)
      (mode == tsmc_pkg::SM_EXTCLK && !rise) |=> !cnt_step
      ) else $error("ext clock step without edge");
   a_reinit_single : assert property (@(posedge clk) disable iff (rst)
      cnt_reinit |=> !cnt_reinit
      ) else $error("reinit longer than one cycle");
   a_sync_on : assert property (@(posedge clk) disable iff (rst)
      (sync_enable && rise) |=> master_sync
      ) else $error("sync edge lost");

   // flag and request paths
   a_trig_dma : assert property (@(posedge clk) disable iff (rst)
      (mode == tsmc_pkg::SM_TRIGGER && rise) |=> dma_req
      ) else $error("dma request lost");
   // clear without a new event must drop the flag
   a_flag_clear : assert property (@(posedge clk) disable iff (rst)
      (clr_wr && wdata[tsmc_pkg::ST_TRIG] && !event_d) |=> !trig_flag
      ) else $error("flag not cleared");
   a_irq_level : assert property (@(posedge clk) disable iff (rst)
      (|(status_d & irq_en_q)) |=> irq
      ) else $error("interrupt missing");
endmodule // tsmc_ctrl

// *** src/tsmc_pkg.sv ***
// constants and types for the timer slave-mode controller
package tsmc_pkg;
   // slave control register layout (index = byte address / 4)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_IRQ_CLR = 4'h2;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
   localparam logic [3:0] ADDR_STATE = 4'h4;
   localparam int SMS_LSB = 0;
   localparam int COSW_BIT = 3;
   localparam int TIS_LSB = 4;
   localparam int SYNC_BIT = 7;
   localparam int POL_BIT = 15;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // status bits
   localparam int ST_TRIG = 0;
   localparam int ST_RESET = 1;
   localparam int ST_CLK = 2;
   localparam int ST_WIDTH = 3;
   localparam logic [ST_WIDTH-1:0] STATUS_RESET = 3'h0;
   // trigger input select codes
   localparam logic [2:0] TIS_CH1_EDGE = 3'h4;
   localparam logic [2:0] TIS_FILT1 = 3'h5;
   localparam logic [2:0] TIS_FILT2 = 3'h6;
   localparam logic [2:0] TIS_EXT = 3'h7;
   // slave mode codes
   typedef enum logic [7:0] {
      SM_OFF = 8'h01,
      SM_ENC_A = 8'h02,
      SM_ENC_B = 8'h04,
      SM_ENC_C = 8'h08,
      SM_RESET = 8'h10,
      SM_GATED = 8'h20,
      SM_TRIGGER = 8'h40,
      SM_EXTCLK = 8'h80
   } tsmc_mode_type;
endpackage

// *** src/tsmc_if.sv ***
// trigger path signals between the controller and its edge detector
`timescale 1ns/100ps
interface tsmc_trig_if;
   logic level;
   logic rise;
   logic level_q;
   modport src (output level, input rise, input level_q);
   modport det (input level, output rise, output level_q);
endinterface

// *** src/tsmc_edge.sv ***
// rising-edge detector for the selected trigger, comparing its level against a registered copy
`timescale 1ns/100ps
module tsmc_edge (
   input wire logic clk,
   input wire logic rst,
   tsmc_trig_if.det trig
);
   logic prev_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= trig.level;
      end
   end
   assign trig.level_q = prev_q;
   // one cycle per low-to-high change only
   assign trig.rise = trig.level & ~prev_q;
   a_edge_single : assert property (@(posedge clk) disable iff (rst)
      trig.rise |=> !trig.rise) else $error("edge pulse longer than one cycle");
endmodule // tsmc_edge

// *** test/tsmc_far_model.sv ***
// far-side model: trigger sources and output-off level
`timescale 1ns/100ps
module tsmc_far_model (
   input wire logic [2:0] src,
   input wire logic lvl,
   input wire logic off_lvl,
   output logic [3:0] internal_trigger_line,
   output logic chan1_edge_detect,
   output logic filtered_input_one,
   output logic filtered_input_two,
   output logic external_trigger_in,
   output logic output_off_signal
);
   // unpicked sources carry the opposite level so a wrong pick shows
   logic [7:0] lines;
   assign lines = {8{~lvl}} ^ (8'h01 << src);
   assign internal_trigger_line = lines[3:0];
   assign chan1_edge_detect = lines[4];
   assign filtered_input_one = lines[5];
   assign filtered_input_two = lines[6];
   assign external_trigger_in = lines[7];
   assign output_off_signal = off_lvl;
endmodule // tsmc_far_model

// *** test/timer_slave_mode_controller_tb_top.sv ***
// testbench for the timer slave-mode controller
`timescale 1ns/100ps
module timer_slave_mode_controller_tb_top;
   logic clk, rst, wr, rd, lvl, off_lvl, tick, clr;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, v;
   logic [2:0] src;
   logic [3:0] internal_trigger_line;
   logic chan1_edge_detect, filtered_input_one, filtered_input_two, external_trigger_in, output_off_signal;
   logic selected_trigger_in, raw_channel_switch, cnt_reinit, cnt_step, enc_enable, trig_event;
   logic trig_flag, dma_req, master_sync, irq;
   logic [1:0] enc_mode;
   logic [4:0] pulses;
   logic [7:0] n [5];
   int miscompares, n_tests;

   tsmc_far_model far (.src, .lvl, .off_lvl, .internal_trigger_line, .chan1_edge_detect, .filtered_input_one,
      .filtered_input_two, .external_trigger_in, .output_off_signal);
   tsmc_ctrl dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .internal_trigger_line, .chan1_edge_detect,
      .filtered_input_one, .filtered_input_two, .external_trigger_in, .output_off_signal,
      .int_clk_tick(tick), .selected_trigger_in, .raw_channel_switch, .cnt_reinit, .cnt_step, .enc_enable,
      .enc_mode, .trig_event, .trig_flag, .dma_req, .master_sync, .irq);

   // pulse tallies: a pulse lasting two cycles shows as a count of two
   assign pulses = {master_sync, dma_req, trig_event, cnt_step, cnt_reinit};
   always @(posedge clk) begin
      for (int i = 0; i < 5; i++) begin
         if (clr) n[i] <= 8'h00;
         else n[i] <= n[i] + {7'h00, pulses[i]};
      end
   end

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, e);
   endtask

   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // one rising edge, held four cycles, tallies cleared beforehand
   task automatic edge_pulse;
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      lvl <= 1'b1;
      repeat (4) @(posedge clk);
      lvl <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask

   task automatic stop_test;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #100us;
      miscompares++;
      stop_test();
   end

   initial begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 16'h0000;
      src = 3'h7; lvl = 1'b0; off_lvl = 1'b0; tick = 1'b0; clr = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd_chk(tsmc_pkg::ADDR_CTRL, tsmc_pkg::CTRL_RESET);
      rd_chk(tsmc_pkg::ADDR_STATUS, 16'h0000);
      rd_chk(tsmc_pkg::ADDR_IRQ_EN, 16'h0000);
      wr_reg(tsmc_pkg::ADDR_CTRL, 16'hffff);
      rd_chk(tsmc_pkg::ADDR_CTRL, 16'h80ff);
      wr_reg(4'h5, 16'hffff);
      rd_chk(4'h5, 16'h0000);
      for (int s = 0; s < 8; s++) begin
         src <= 3'(s);
         wr_reg(tsmc_pkg::ADDR_CTRL, 16'(s) << tsmc_pkg::TIS_LSB);
         for (int l = 0; l < 2; l++) begin
            lvl <= 1'(l);
            settle();
            check(16'(selected_trigger_in), 16'(l));
         end
      end
      lvl <= 1'b0;
      wr_reg(tsmc_pkg::ADDR_CTRL, 16'h8070);
      settle();
      check(16'(selected_trigger_in), 16'h0001);
      check(16'(raw_channel_switch), 16'h0001);
      off_lvl <= 1'b1;
      wr_reg(tsmc_pkg::ADDR_CTRL, 16'h0078);
      settle();
      check(16'(raw_channel_switch), 16'h0001);
      check(16'(selected_trigger_in), 16'h0000);
      off_lvl <= 1'b0;
      settle();
      check(16'(raw_channel_switch), 16'h0000);
      for (int m = 0; m < 8; m++) begin
         wr_reg(tsmc_pkg::ADDR_CTRL, 16'h00f0 | 16'(m));
         settle();
         check(16'(enc_enable), 16'(m >= 1 && m <= 3));
         if (m >= 1 && m <= 3) check(16'(enc_mode), 16'(m));
         edge_pulse();
         check(16'(n[0]), 16'(m == 4));
         check(16'(n[1]), 16'(m == 7));
         check(16'(n[2]), 16'(m == 6));
         check(16'(n[3]), 16'(m == 6));
         check(16'(n[4]), 16'h0001);
      end
      rd_chk(tsmc_pkg::ADDR_STATE, 16'h0001);
      wr_reg(tsmc_pkg::ADDR_CTRL, 16'h0076);
      edge_pulse();
      check(16'(n[4]), 16'h0000);
      rd_chk(tsmc_pkg::ADDR_STATUS, 16'h0007);
      check(16'(trig_flag), 16'h0001);
      check(16'(irq), 16'h0000);
      wr_reg(tsmc_pkg::ADDR_IRQ_EN, 16'h0001);
      settle();
      check(16'(irq), 16'h0001);
      wr_reg(tsmc_pkg::ADDR_IRQ_CLR, 16'h0001);
      settle();
      check(16'(irq), 16'h0000);
      check(16'(trig_flag), 16'h0000);
      rd_chk(tsmc_pkg::ADDR_STATUS, 16'h0006);
      wr_reg(tsmc_pkg::ADDR_IRQ_EN, 16'h0006);
      settle();
      check(16'(irq), 16'h0001);
      wr_reg(tsmc_pkg::ADDR_IRQ_CLR, 16'h0007);
      settle();
      check(16'(irq), 16'h0000);
      // gated mode: ticks pass only while the trigger is high
      tick <= 1'b1;
      wr_reg(tsmc_pkg::ADDR_CTRL, 16'h0075);
      edge_pulse();
      check(16'(n[1]), 16'h0004);
      tick <= 1'b0;
      stop_test();
   end
endmodule // timer_slave_mode_controller_tb_top
